// >>> hw/cfgd_pkg.sv
// cfgd_pkg: constants for the boot clock and watchdog configuration decoder
// assumes one hclk domain, an AHB-Lite slave port and a word-wide nvm reader
// Behaviour
// - window size code 11/10/01/00 opens 25/37.5/50/75 percent of the period
// - force-on bit one: watchdog runs, software cannot stop it; zero: software may
// - window-off bit one selects non-window mode, zero selects window mode
// - postscale code n divides by two to the n, 1:1 up to 1:1048576
// - postscale codes above 10100 act as 10100
// - clock switch code 1x disables both, 01 switching only, 00 both on
// - peripheral bus clock is system clock over 1, 2, 4 or 8
// - clock output only when its disable bit is zero and primary is 11 or 00
// - primary type 11 off, 10 high-speed crystal, 01 crystal, 00 external clock
// - switchover bit one enables two-speed start-up
// - secondary oscillator on when its bit is one
// - start-up source code picks one of eight oscillator sources
// - system pll output divisor 1,2,4,8,16,32,64,256
// - usb pll bit zero enables it, one disables and bypasses it
// - usb pll input divisor 1,2,3,4,5,6,10,12
// - system pll multiplier 15 to 21, then 24
// - system pll input divisor 1,2,3,4,5,6,10,12
// - usb pll fields exist only on the usb variant
package cfgd_pkg;
    localparam logic [7:0] CFGD_WORD1_OFS = 8'h00;
    localparam logic [7:0] CFGD_WORD2_OFS = 8'h04;
    localparam logic [7:0] CFGD_STAT_OFS = 8'h08;
    localparam logic [7:0] CFGD_CTRL_OFS = 8'h0c;
    localparam logic [31:0] CFGD_ERASED = 32'hffff_ffff;
    localparam logic [31:0] CFGD_W1_RSV = 32'hfc20_0858;
    localparam logic [31:0] CFGD_W2_RSV = 32'hfff8_7888;
    localparam logic [31:0] CFGD_W2_USB = 32'h0000_8700;
    localparam logic [2:0] CFGD_HSIZE_WORD = 3'h2;
    localparam logic CFGD_NVM_W1 = 1'b0;
    localparam logic CFGD_NVM_W2 = 1'b1;
    localparam logic [4:0] CFGD_PS_MAX = 5'h14;
    localparam int W1_WINSZ = 24;
    localparam int W1_FORCE = 23;
    localparam int W1_WINOFF = 22;
    localparam int W1_PS = 16;
    localparam int W1_CKSM = 14;
    localparam int W1_PBDIV = 12;
    localparam int W1_CKOD = 10;
    localparam int W1_POSC = 8;
    localparam int W1_TWOSP = 7;
    localparam int W1_SOSC = 5;
    localparam int W1_NOSC = 0;
    localparam int W2_ODIV = 16;
    localparam int W2_UBYP = 15;
    localparam int W2_UIDIV = 8;
    localparam int W2_MUL = 4;
    localparam int W2_IDIV = 0;
    localparam int STAT_LOADED = 0;
    localparam int STAT_CONFLICT = 1;
    localparam int STAT_RSV_BAD = 2;
    localparam int CTRL_RELOAD = 0;
    typedef enum logic [1:0] {CFGD_LD1, CFGD_LD2, CFGD_RUN} cfgd_state_e;
endpackage

// >>> hw/cfgd_field_decode.sv
// cfgd_field_decode: turns the two latched configuration words into settings
// assumes words are stable register outputs; purely combinational
module cfgd_field_decode import cfgd_pkg::*; #(
    parameter bit USB_VARIANT = 1'b1
) (
    input wire logic [31:0] word1, // clock and watchdog word
    input wire logic [31:0] word2, // pll word
    output logic [3:0] win, // open window in eighths
    output logic [4:0] ps, // postscale exponent
    output logic [3:0] pbd, // peripheral bus divisor
    output logic cko, // clock output enable
    output logic [3:0] posc, // primary type, one-hot by code
    output logic [7:0] src, // start-up source, one-hot by code
    output logic [8:0] odiv, // system pll output divisor
    output logic upll, // usb pll running
    output logic [3:0] uidiv, // usb pll input divisor
    output logic [4:0] mul, // system pll multiplier
    output logic [3:0] idiv, // system pll input divisor
    output logic conflict, // primary start-up with primary off
    output logic rsv_bad // a reserved bit reads zero
);
    function automatic logic [3:0] in_div(input logic [2:0] c);
        case (c)
            3'h6: in_div = 4'ha;
            3'h7: in_div = 4'hc;
            default: in_div = 4'({1'b0, c} + 4'h1);
        endcase
    endfunction

    logic [4:0] ps_raw;
    logic [2:0] nosc;
    logic [2:0] odc;
    assign ps_raw = word1[W1_PS+:5];
    assign nosc = word1[W1_NOSC+:3];
    assign odc = word2[W2_ODIV+:3];

    always_comb begin
        case (word1[W1_WINSZ+:2])
            2'h3: win = 4'h2;
            2'h2: win = 4'h3;
            2'h1: win = 4'h4;
            default: win = 4'h6;
        endcase
    end

    assign ps = (ps_raw > CFGD_PS_MAX) ? CFGD_PS_MAX : ps_raw;
    assign pbd = 4'(4'h1 << word1[W1_PBDIV+:2]);
    assign posc = 4'(4'h1 << word1[W1_POSC+:2]);
    // only off or external clock frees the pin for the clock output
    assign cko = !word1[W1_CKOD] && (posc[3] || posc[0]);
    assign src = 8'(8'h1 << nosc);
    assign odiv = (odc == 3'h7) ? 9'h100 : 9'(9'h1 << odc);
    assign mul = (word2[W2_MUL+:3] == 3'h7) ? 5'h18 : 5'(5'hf + word2[W2_MUL+:3]);
    assign idiv = in_div(word2[W2_IDIV+:3]);
    // a part without usb keeps its usb pll parked and undivided
    assign upll = USB_VARIANT && !word2[W2_UBYP];
    assign uidiv = USB_VARIANT ? in_div(word2[W2_UIDIV+:3]) : 4'h1;
    assign conflict = (src[2] || src[3]) && posc[3];
    assign rsv_bad = ((word1 & CFGD_W1_RSV) != CFGD_W1_RSV)
        || ((word2 & CFGD_W2_RSV) != CFGD_W2_RSV);
endmodule // cfgd_field_decode

// >>> hw/cfgd_top.sv
// cfgd_top: boot configuration loader with an AHB-Lite register view
// assumes an nvm reader on hclk that answers each request with a one-cycle ack
module cfgd_top import cfgd_pkg::*; #(
    parameter bit USB_VARIANT = 1'b1
) (
    input wire logic hclk, // system clock, 20 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    output logic nvm_rd_req, // nvm read request, held until ack
    output logic nvm_rd_addr, // which word to fetch
    input wire logic nvm_rd_ack, // nvm data valid
    input wire logic [31:0] nvm_rd_data, // nvm word
    output logic config_loaded, // both words latched
    output logic [3:0] open_window_eighths, // open window share
    output logic watchdog_force_on, // watchdog runs, locked on
    output logic watchdog_sw_may_enable, // software may start it
    output logic watchdog_window_off, // non-window mode
    output logic [4:0] watchdog_postscale_exp, // divide by 2**exp
    output logic clock_switch_en, // clock switching allowed
    output logic fail_safe_monitor_en, // fail-safe monitor on
    output logic [3:0] periph_bus_divisor_val, // system over this
    output logic clock_output_en, // clock output on its pin
    output logic [3:0] primary_osc_onehot, // ec, xt, hs, off
    output logic two_speed_startup_on, // two-speed start-up
    output logic secondary_osc_on, // secondary oscillator on
    output logic [7:0] startup_src_onehot, // start-up source
    output logic startup_uses_pll, // source goes through pll
    output logic [8:0] sys_pll_output_divisor_val, // pll out divisor
    output logic usb_pll_en, // usb pll running
    output logic [3:0] usb_pll_input_divisor_val, // usb pll in divisor
    output logic [4:0] sys_pll_multiplier_val, // pll multiplier
    output logic [3:0] sys_pll_input_divisor_val, // pll in divisor
    output logic osc_conflict, // bad programming seen
    output logic reserved_bad // a reserved bit is zero
);
    typedef struct packed {
        logic [3:0] win;
        logic force_on;
        logic may_en;
        logic win_off;
        logic [4:0] ps;
        logic csw;
        logic fsm;
        logic [3:0] pbd;
        logic cko;
        logic [3:0] posc;
        logic tss;
        logic sosc;
        logic [7:0] src;
        logic spll;
        logic [8:0] odiv;
        logic upll;
        logic [3:0] uidiv;
        logic [4:0] mul;
        logic [3:0] idiv;
        logic conflict;
        logic rsv_bad;
    } cfgd_dec_s;

    typedef struct packed {
        cfgd_state_e st;
        logic [31:0] word1;
        logic [31:0] word2;
        logic req;
        logic addr;
        logic loaded;
        logic dp_wr;
        logic [7:0] dp_ofs;
        logic [31:0] rdata;
        logic rdy;
        cfgd_dec_s dec;
    } cfgd_regs_s;

    cfgd_regs_s q;
    cfgd_regs_s n;

    logic [3:0] d_win;
    logic [4:0] d_ps;
    logic [3:0] d_pbd;
    logic d_cko;
    logic [3:0] d_posc;
    logic [7:0] d_src;
    logic [8:0] d_odiv;
    logic d_upll;
    logic [3:0] d_uidiv;
    logic [4:0] d_mul;
    logic [3:0] d_idiv;
    logic d_conflict;
    logic d_rsv_bad;
    logic addr_take;
    logic [31:0] rd_val;

    cfgd_field_decode #(
        .USB_VARIANT(USB_VARIANT)
    ) u_dec (
        .word1(q.word1),
        .word2(q.word2),
        .win(d_win),
        .ps(d_ps),
        .pbd(d_pbd),
        .cko(d_cko),
        .posc(d_posc),
        .src(d_src),
        .odiv(d_odiv),
        .upll(d_upll),
        .uidiv(d_uidiv),
        .mul(d_mul),
        .idiv(d_idiv),
        .conflict(d_conflict),
        .rsv_bad(d_rsv_bad)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign addr_take = hsel && hready && htrans[1];

    always_comb begin
        case (haddr[7:0])
            CFGD_WORD1_OFS: rd_val = q.word1;
            CFGD_WORD2_OFS: rd_val = q.word2;
            CFGD_STAT_OFS: rd_val = {29'h0, q.dec.rsv_bad, q.dec.conflict, q.loaded};
            default: rd_val = 32'h0;
        endcase
        if (haddr[31:8] != 24'h0) begin
            rd_val = 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = q;
        n.rdy = 1'b1;
        n.dp_wr = 1'b0;
        if (addr_take) begin
            n.dp_wr = hwrite && (hsize == CFGD_HSIZE_WORD) && (haddr[31:8] == 24'h0);
            n.dp_ofs = haddr[7:0];
            n.rdata = hwrite ? 32'h0 : rd_val;
        end
        case (q.st)
            CFGD_LD1: begin
                if (nvm_rd_ack) begin
                    n.word1 = nvm_rd_data;
                    n.addr = CFGD_NVM_W2;
                    n.st = CFGD_LD2;
                end
            end
            CFGD_LD2: begin
                if (nvm_rd_ack) begin
                    // missing usb fields read as erased ones
                    n.word2 = nvm_rd_data | (USB_VARIANT ? 32'h0 : CFGD_W2_USB);
                    n.req = 1'b0;
                    n.loaded = 1'b1;
                    n.st = CFGD_RUN;
                end
            end
            CFGD_RUN: begin
                // config words ignore writes; only the reload strobe acts
                if (q.dp_wr && q.dp_ofs == CFGD_CTRL_OFS && hwdata[CTRL_RELOAD]) begin
                    n.st = CFGD_LD1;
                    n.req = 1'b1;
                    n.addr = CFGD_NVM_W1;
                    n.loaded = 1'b0;
                end
            end
            default: begin
                n.st = CFGD_LD1;
                n.req = 1'b1;
                n.addr = CFGD_NVM_W1;
            end
        endcase
        n.dec.win = d_win;
        n.dec.force_on = q.word1[W1_FORCE];
        n.dec.may_en = !q.word1[W1_FORCE];
        n.dec.win_off = q.word1[W1_WINOFF];
        n.dec.ps = d_ps;
        n.dec.csw = !q.word1[W1_CKSM + 1];
        n.dec.fsm = q.word1[W1_CKSM+:2] == 2'h0;
        n.dec.pbd = d_pbd;
        n.dec.cko = d_cko;
        n.dec.posc = d_posc;
        n.dec.tss = q.word1[W1_TWOSP];
        n.dec.sosc = q.word1[W1_SOSC];
        n.dec.src = d_src;
        n.dec.spll = d_src[1] || d_src[3];
        n.dec.odiv = d_odiv;
        n.dec.upll = d_upll;
        n.dec.uidiv = d_uidiv;
        n.dec.mul = d_mul;
        n.dec.idiv = d_idiv;
        n.dec.conflict = d_conflict;
        n.dec.rsv_bad = d_rsv_bad;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.st <= CFGD_LD1;
            q.word1 <= CFGD_ERASED;
            q.word2 <= CFGD_ERASED;
            q.req <= 1'b1;
            q.addr <= CFGD_NVM_W1;
            q.rdy <= 1'b1;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign hreadyout = q.rdy;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign nvm_rd_req = q.req;
    assign nvm_rd_addr = q.addr;
    assign config_loaded = q.loaded;
    assign open_window_eighths = q.dec.win;
    assign watchdog_force_on = q.dec.force_on;
    assign watchdog_sw_may_enable = q.dec.may_en;
    assign watchdog_window_off = q.dec.win_off;
    assign watchdog_postscale_exp = q.dec.ps;
    assign clock_switch_en = q.dec.csw;
    assign fail_safe_monitor_en = q.dec.fsm;
    assign periph_bus_divisor_val = q.dec.pbd;
    assign clock_output_en = q.dec.cko;
    assign primary_osc_onehot = q.dec.posc;
    assign two_speed_startup_on = q.dec.tss;
    assign secondary_osc_on = q.dec.sosc;
    assign startup_src_onehot = q.dec.src;
    assign startup_uses_pll = q.dec.spll;
    assign sys_pll_output_divisor_val = q.dec.odiv;
    assign usb_pll_en = q.dec.upll;
    assign usb_pll_input_divisor_val = q.dec.uidiv;
    assign sys_pll_multiplier_val = q.dec.mul;
    assign sys_pll_input_divisor_val = q.dec.idiv;
    assign osc_conflict = q.dec.conflict;
    assign reserved_bad = q.dec.rsv_bad;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // decoded outputs lag the latched words by one register, hence the $past on each word
    win_size_a: assert property ($past(hresetn) |-> open_window_eighths ==
        (($past(q.word1[25:24]) == 2'h3) ? 4'h2 : ($past(q.word1[25:24]) == 2'h2) ? 4'h3 :
        ($past(q.word1[25:24]) == 2'h1) ? 4'h4 : 4'h6))
        else $error("window size decode wrong");
    wdt_force_a: assert property ($past(hresetn) |->
        watchdog_force_on == $past(q.word1[23]) && watchdog_sw_may_enable != watchdog_force_on)
        else $error("watchdog force decode wrong");
    win_off_a: assert property ($past(hresetn) |-> watchdog_window_off == $past(q.word1[22]))
        else $error("window mode decode wrong");
    ps_clamp_a: assert property ($past(hresetn) |-> watchdog_postscale_exp ==
        (($past(q.word1[20:16]) > 5'h14) ? 5'h14 : $past(q.word1[20:16])))
        else $error("postscale decode wrong");
    clk_switch_a: assert property ($past(hresetn) |->
        clock_switch_en == !$past(q.word1[15]) && fail_safe_monitor_en == ($past(q.word1[15:14]) == 2'h0))
        else $error("clock switch decode wrong");
    clk_out_a: assert property ($past(hresetn) && clock_output_en |->
        !$past(q.word1[10]) && ($past(q.word1[9:8]) == 2'h3 || $past(q.word1[9:8]) == 2'h0))
        else $error("clock output wrongly enabled");
    pll_odiv_a: assert property ($past(hresetn) && $past(q.word2[18:16]) == 3'h7 |->
        sys_pll_output_divisor_val == 9'h100)
        else $error("pll output divisor wrong");
    pll_mul_a: assert property ($past(hresetn) |-> sys_pll_multiplier_val ==
        (($past(q.word2[6:4]) == 3'h7) ? 5'h18 : 5'(5'hf + $past(q.word2[6:4]))))
        else $error("pll multiplier wrong");
    usb_pll_a: assert property ($past(hresetn) |->
        usb_pll_en == (USB_VARIANT && !$past(q.word2[15])))
        else $error("usb pll enable wrong");
    ps_range_a: assert property ($past(hresetn) && $past(q.word1[20:16]) <= 5'h14
        |-> watchdog_postscale_exp == $past(q.word1[20:16]))
        else $error("postscale ratio wrong");
    pb_div_a: assert property ($past(hresetn) |->
        periph_bus_divisor_val == 4'(4'h1 << $past(q.word1[13:12])))
        else $error("bus clock divisor wrong");
    posc_mode_a: assert property ($past(hresetn) |->
        primary_osc_onehot == 4'(4'h1 << $past(q.word1[9:8])))
        else $error("primary oscillator decode wrong");
    two_speed_a: assert property ($past(hresetn) |->
        two_speed_startup_on == $past(q.word1[7]))
        else $error("two-speed start-up decode wrong");
    sosc_en_a: assert property ($past(hresetn) |->
        secondary_osc_on == $past(q.word1[5]))
        else $error("secondary oscillator decode wrong");
    start_src_a: assert property ($past(hresetn) |->
        startup_src_onehot == 8'(8'h1 << $past(q.word1[2:0])) &&
        startup_uses_pll == ($past(q.word1[2:0]) == 3'h1 || $past(q.word1[2:0]) == 3'h3))
        else $error("start-up source decode wrong");
    osc_flag_a: assert property ($past(hresetn) |-> osc_conflict ==
        ($past(q.word1[9:8]) == 2'h3 && $past(q.word1[2:1]) == 2'h1))
        else $error("oscillator conflict flag wrong");
    odiv_all_a: assert property ($past(hresetn) && $past(q.word2[18:16]) != 3'h7
        |-> sys_pll_output_divisor_val == 9'(9'h1 << $past(q.word2[18:16])))
        else $error("pll output divisor wrong");
    usb_idiv_a: assert property ($past(hresetn) |-> usb_pll_input_divisor_val ==
        (!USB_VARIANT ? 4'h1 : ($past(q.word2[10:8]) == 3'h7) ? 4'hc :
        ($past(q.word2[10:8]) == 3'h6) ? 4'ha : 4'({1'b0, $past(q.word2[10:8])} + 4'h1)))
        else $error("usb pll input divisor wrong");
    pll_idiv_a: assert property ($past(hresetn) |-> sys_pll_input_divisor_val ==
        (($past(q.word2[2:0]) == 3'h7) ? 4'hc : ($past(q.word2[2:0]) == 3'h6) ? 4'ha :
        4'({1'b0, $past(q.word2[2:0])} + 4'h1)))
        else $error("pll input divisor wrong");
    rsv_flag_a: assert property ($past(hresetn) |-> reserved_bad ==
        (($past(q.word1) & CFGD_W1_RSV) != CFGD_W1_RSV ||
        ($past(q.word2) & CFGD_W2_RSV) != CFGD_W2_RSV))
        else $error("reserved bit flag wrong");
    load_first_a: assert property (q.st == CFGD_LD1 && nvm_rd_ack |=>
        nvm_rd_req && nvm_rd_addr == CFGD_NVM_W2 && q.word1 == $past(nvm_rd_data))
        else $error("first config word not latched");
    load_seq_a: assert property (q.st == CFGD_LD2 && nvm_rd_ack |=>
        config_loaded && !nvm_rd_req && q.st == CFGD_RUN)
        else $error("load did not finish after second word");
    rd_word_a: assert property (addr_take && !hwrite &&
        haddr == {24'h0, CFGD_WORD2_OFS} |=> hrdata == $past(q.word2))
        else $error("config word read wrong");
    wr_ignored_a: assert property (q.st == CFGD_RUN && q.dp_wr &&
        q.dp_ofs != CFGD_CTRL_OFS |=> q.st == CFGD_RUN && config_loaded)
        else $error("write to a read-only offset acted");
    // an nvm answer that arrives in run must be refused as well
    ro_words_a: assert property (q.st == CFGD_RUN |=>
        $stable(q.word1) && $stable(q.word2))
        else $error("config word changed at run time");

    // covers: first load, reload from run, clamped postscale, bad programming flagged
    load_done_c: cover property ($rose(config_loaded));
    reload_c: cover property (q.st == CFGD_RUN ##1 q.st == CFGD_LD1);
    ps_clamp_c: cover property (q.word1[20:16] > 5'h14);
    conflict_c: cover property (osc_conflict);
    rsv_bad_c: cover property (reserved_bad);
endmodule // cfgd_top

// >>> dv/tb_cfgd_top.sv
// tb_cfgd_top: self-checking bench for the boot configuration decoder
// assumes cfgd_top with a zero-wait AHB-Lite slave; the bench plays the nvm reader itself
module tb_cfgd_top import cfgd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, nvm_rd_data;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic nvm_rd_req, nvm_rd_addr, nvm_rd_ack, config_loaded;
    logic [3:0] open_window_eighths, periph_bus_divisor_val, primary_osc_onehot;
    logic [3:0] usb_pll_input_divisor_val, sys_pll_input_divisor_val;
    logic [4:0] watchdog_postscale_exp, sys_pll_multiplier_val;
    logic [7:0] startup_src_onehot;
    logic [8:0] sys_pll_output_divisor_val;
    logic watchdog_force_on, watchdog_sw_may_enable, watchdog_window_off, clock_switch_en;
    logic fail_safe_monitor_en, clock_output_en, two_speed_startup_on, secondary_osc_on;
    logic startup_uses_pll, usb_pll_en, osc_conflict, reserved_bad;
    int fail_count = 0;
    int checked = 0;
    logic [3:0] win_tab [4] = '{4'h6, 4'h4, 4'h3, 4'h2};
    logic [3:0] div_tab [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};
    logic [4:0] mul_tab [8] = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
    // postscale codes probe both ends of the table and the clamp above it
    logic [4:0] ps_tab [8] = '{5'h00, 5'h01, 5'h05, 5'h13, 5'h14, 5'h15, 5'h1f, 5'h0a};

    // single slave, so its own ready is the bus ready
    assign hready = hreadyout;

    cfgd_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_ack,
        .nvm_rd_data, .config_loaded, .open_window_eighths, .watchdog_force_on,
        .watchdog_sw_may_enable, .watchdog_window_off, .watchdog_postscale_exp,
        .clock_switch_en, .fail_safe_monitor_en, .periph_bus_divisor_val, .clock_output_en,
        .primary_osc_onehot, .two_speed_startup_on, .secondary_osc_on, .startup_src_onehot,
        .startup_uses_pll, .sys_pll_output_divisor_val, .usb_pll_en,
        .usb_pll_input_divisor_val, .sys_pll_multiplier_val, .sys_pll_input_divisor_val,
        .osc_conflict, .reserved_bad);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for a design flag, sampled at rising edges
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (s !== 1'b1 && n < 200);
        if (s !== 1'b1) begin
            fail_count++;
            end_sim();
        end
    endtask

    // one single AHB-Lite word transfer; read data taken at the data-phase ready edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= CFGD_HSIZE_WORD;
        wait_hi(hreadyout);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_hi(hreadyout);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask

    // answer one nvm request; data goes stale right after the ack
    task automatic nvm_ack(input logic a, input logic [31:0] d);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (!(nvm_rd_req === 1'b1 && nvm_rd_addr === a) && n < 200);
        if (nvm_rd_req !== 1'b1 || nvm_rd_addr !== a) begin
            fail_count++;
            end_sim();
        end
        nvm_rd_ack <= 1'b1;
        nvm_rd_data <= d;
        @(posedge hclk);
        nvm_rd_ack <= 1'b0;
        nvm_rd_data <= ~d;
    endtask

    task automatic load(input logic [31:0] w1, input logic [31:0] w2);
        nvm_ack(CFGD_NVM_W1, w1);
        nvm_ack(CFGD_NVM_W2, w2);
        wait_hi(config_loaded);
        @(posedge hclk);
    endtask

    task automatic reload(input logic [31:0] w1, input logic [31:0] w2);
        logic [31:0] rd;
        ahb(1'b1, CFGD_CTRL_OFS, 32'h0000_0001, rd);
        @(posedge hclk);
        chk(config_loaded, 1'b0);
        load(w1, w2);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        logic [31:0] w1, w2, rd;
        logic [2:0] c;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = CFGD_HSIZE_WORD;
        hwdata = 32'h0;
        nvm_rd_ack = 1'b0;
        nvm_rd_data = 32'h0;
        repeat (3) @(posedge hclk);
        chk(config_loaded, 1'b0);
        chk({hreadyout, nvm_rd_req, nvm_rd_addr, open_window_eighths}, 7'h60);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, CFGD_WORD1_OFS, 32'h0, rd);
        chk(rd, CFGD_ERASED);
        load(CFGD_ERASED, CFGD_ERASED);
        $display("test reset and first load done");

        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            // reserved bits come from the masks, so no word flags reserved_bad; only c == 3 flags an oscillator conflict
            w1 = CFGD_W1_RSV | {6'h0, c[1:0], c[0], c[1], 1'b0, ps_tab[i], c[1:0], ~c[1:0],
                1'b0, c[2], c[1:0], c[0], 1'b0, c[1], 2'b0, c};
            w2 = CFGD_W2_RSV | {13'h0, c, ~c[0], 4'h0, ~c, 1'b0, c, 1'b0, c ^ 3'h2};
            reload(w1, w2);
            chk(open_window_eighths, win_tab[c[1:0]]);
            chk({watchdog_force_on, watchdog_sw_may_enable}, {c[0], ~c[0]});
            chk(watchdog_window_off, c[1]);
            chk(watchdog_postscale_exp, ps_tab[i] > 5'h14 ? 5'h14 : ps_tab[i]);
            chk({clock_switch_en, fail_safe_monitor_en}, {~c[1], c[1:0] == 2'h0});
            chk(periph_bus_divisor_val, 4'h1 << 2'(~c[1:0]));
            chk(clock_output_en, !c[2] && (c[1:0] == 2'h3 || c[1:0] == 2'h0));
            chk(primary_osc_onehot, 4'h1 << c[1:0]);
            chk(two_speed_startup_on, c[0]);
            chk(secondary_osc_on, c[1]);
            chk(startup_src_onehot, 8'h01 << c);
            chk(startup_uses_pll, c == 3'h1 || c == 3'h3);
            chk(osc_conflict, c == 3'h3);
            chk(sys_pll_output_divisor_val, c == 3'h7 ? 9'h100 : 9'h001 << c);
            chk(usb_pll_en, c[0]);
            chk(usb_pll_input_divisor_val, div_tab[3'(~c)]);
            chk(sys_pll_multiplier_val, mul_tab[c]);
            chk(sys_pll_input_divisor_val, div_tab[c ^ 3'h2]);
            chk(reserved_bad, 1'b0);
            ahb(1'b0, CFGD_WORD1_OFS, 32'h0, rd);
            chk(rd, w1);
            ahb(1'b0, CFGD_WORD2_OFS, 32'h0, rd);
            chk(rd, w2);
            ahb(1'b0, CFGD_STAT_OFS, 32'h0, rd);
            chk(rd, {29'h0, 1'b0, c == 3'h3, 1'b1});
        end
        $display("test field decode table done");

        // the words are read-only: a write must leave them as latched
        ahb(1'b1, CFGD_WORD1_OFS, 32'h0000_0000, rd);
        ahb(1'b0, CFGD_WORD1_OFS, 32'h0, rd);
        chk(rd, w1);
        ahb(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0);
        // an nvm answer with no request pending must not touch the words
        nvm_rd_ack <= 1'b1;
        nvm_rd_data <= 32'h0;
        @(posedge hclk);
        nvm_rd_ack <= 1'b0;
        ahb(1'b0, CFGD_WORD2_OFS, 32'h0, rd);
        chk(rd, w2);
        chk(config_loaded, 1'b1);
        // a cleared reserved bit is flagged, and postscale 11111 still clamps
        reload(32'hffdf_ffff, CFGD_ERASED);
        chk(reserved_bad, 1'b1);
        chk(watchdog_postscale_exp, 5'h14);
        ahb(1'b0, CFGD_STAT_OFS, 32'h0, rd);
        chk(rd, 32'h0000_0005);
        $display("test read-only and reserved done");

        // a reset in mid-run falls back to erased words, then latches the last table words w1 and w2 again
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({config_loaded, nvm_rd_req, nvm_rd_addr, usb_pll_en}, 4'h4);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, CFGD_WORD1_OFS, 32'h0, rd);
        chk(rd, CFGD_ERASED);
        load(w1, w2);
        chk(startup_src_onehot, 8'h80);
        chk(sys_pll_output_divisor_val, 9'h100);
        chk(reserved_bad, 1'b0);
        $display("test reset in mid-run done");
        end_sim();
    end
endmodule // tb_cfgd_top
